// file: src/fan_thermal_pkg.sv
/*
 Shared constants and types of the fan and thermal monitor status and
 configuration logic. Assumes a 100 MHz system clock.
*/
package fan_thermal_pkg;
	localparam int CLK_HZ             = 100_000_000;
	localparam int TIMEOUT_MS         = 30;
	localparam int RESET_DELAY_MS     = 240;
	localparam int TIMEOUT_CYCLES     = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int RESET_DELAY_CYCLES = RESET_DELAY_MS * (CLK_HZ / 1000);

	localparam logic [7:0] CMD_READ_STATUS  = 8'h02;
	localparam logic [7:0] CMD_READ_CONFIG  = 8'h03;
	localparam logic [7:0] CMD_WRITE_CONFIG = 8'h09;
	localparam logic [7:0] CMD_ONE_SHOT     = 8'h0F;

	localparam logic [6:0] DEVICE_ADDR         = 7'h3D;
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;

	localparam int CFG_MASK_BIT          = 7;
	localparam int CFG_FAIL_DETECT_BIT   = 5;
	localparam int CFG_CONTROL_LOSS_BIT  = 4;
	localparam int CFG_LOOP_BIT          = 1;
	localparam logic [7:0] CONFIG_RESET    = 8'h02;
	localparam logic [7:0] CONFIG_WRITABLE = 8'hB2;

	localparam int ST_BUSY_BIT    = 7;
	localparam int ST_FAIL_BIT    = 6;
	localparam int ST_CONTROL_BIT = 5;
	localparam int ST_DIODE3_BIT  = 3;
	localparam int ST_DIODE2_BIT  = 2;
	localparam int ST_DIODE1_BIT  = 1;

	typedef enum logic [5:0] {
		BUS_IDLE = 6'h01,
		BUS_ADDR = 6'h02,
		BUS_ACK  = 6'h04,
		BUS_RECV = 6'h08,
		BUS_SEND = 6'h10,
		BUS_MACK = 6'h20
	} bus_state_t;

	typedef struct packed {
		logic converterBusy;
		logic fanFailure;
		logic fanOutOfControl;
		logic diodeThreeOpen;
		logic diodeTwoOpen;
		logic diodeOneOpen;
	} fault_in_t;

	typedef struct packed {
		logic        sclMeta;
		logic        sclSync;
		logic        sclPrev;
		logic        sdaMeta;
		logic        sdaSync;
		logic        sdaPrev;
		fault_in_t   faultMeta;
		fault_in_t   faultSync;
		logic        supplyMeta;
		logic        supplySync;
		bus_state_t  busState;
		logic [3:0]  bitCount;
		logic [7:0]  shiftByte;
		logic        readNotWrite;
		logic        alertResponse;
		logic        gotCommand;
		logic [7:0]  pointer;
		logic [7:0]  controlSettings;
		logic [7:0]  faultFlags;
		logic        alertLatch;
		logic        sdaDrive;
		logic        alertDrive;
		logic [31:0] timeoutCount;
		logic [31:0] resetCount;
		logic        resetRelease;
		logic        conversionStart;
	} regs_t;

	localparam regs_t REGS_RESET = '{
		sclMeta:         1'b1,
		sclSync:         1'b1,
		sclPrev:         1'b1,
		sdaMeta:         1'b1,
		sdaSync:         1'b1,
		sdaPrev:         1'b1,
		busState:        BUS_IDLE,
		controlSettings: CONFIG_RESET,
		default:         '0
	};
endpackage

// file: src/fan_thermal_status_config_regs.sv
/*
 SMBus slave holding the status and configuration bytes of the fan and
 thermal monitor, with the alert latch and the supply reset delay.
 Assumes SCL, SDA, fault and supply inputs are asynchronous to sys_clk;
 open-drain pins are resolved outside from the low-active enables.
*/
// Contract
// - Status read clears flags, live faults stay
// - Status bit 7 shows converter busy
// - Status bit 6 flags fan failure
// - Status bit 5 flags fan out-of-control
// - Status bits 3..1 flag open diodes
// - Status bits 4 and 0 read zero
// - Fault flags sticky until reset or read
// - Config read 03h, write 09h
// - Config bit 7 masks alert output
// - Config bit 5 enables fan failure detection
// - Config bit 4 enables control loss detection
// - Config bit 1 loop mode, resets 1
// - Reset output high 240ms after supply good
// - Alert low while any non-busy flag set
// - Alert latched, released by alert response read
// - SCL low over 30ms resets bus interface
`timescale 1ns/1ps
module fan_thermal_status_config_regs #(
	parameter int unsigned TIMEOUT_CYCLES     = fan_thermal_pkg::TIMEOUT_CYCLES,
	parameter int unsigned RESET_DELAY_CYCLES = fan_thermal_pkg::RESET_DELAY_CYCLES
) (
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	input  wire logic                      sclIn,
	input  wire logic                      sdaIn,
	output logic                           sdaOut,
	output logic                           sdaOe_n,
	output logic                           alertOut,
	output logic                           alertOe_n,
	input  wire fan_thermal_pkg::fault_in_t faultIn,
	input  wire logic                      supplyGood,
	output logic                           resetOut_n,
	output logic                           conversionStart,
	output logic                           fanLoopSelect
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] statusByte(input logic [7:0] flags, input logic busy);
		statusByte = flags;
		statusByte[fan_thermal_pkg::ST_BUSY_BIT] = busy;
	endfunction

	function automatic logic [7:0] readMux(input logic [7:0] ptr, input logic [7:0] status,
		input logic [7:0] cfg);
		case (ptr)
			fan_thermal_pkg::CMD_READ_STATUS: readMux = status;
			fan_thermal_pkg::CMD_READ_CONFIG: readMux = cfg;
			default:                          readMux = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	fan_thermal_pkg::regs_t state_reg;
	fan_thermal_pkg::regs_t state_next;

	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;
	logic       addrMatch;
	logic       araMatch;
	logic       clearStatus;
	logic       releaseAlert;
	logic [7:0] setFlags;
	logic [7:0] txByte;

	always_comb begin
		state_next = state_reg;
		state_next.sclMeta    = sclIn;
		state_next.sclSync    = state_reg.sclMeta;
		state_next.sclPrev    = state_reg.sclSync;
		state_next.sdaMeta    = sdaIn;
		state_next.sdaSync    = state_reg.sdaMeta;
		state_next.sdaPrev    = state_reg.sdaSync;
		state_next.faultMeta  = faultIn;
		state_next.faultSync  = state_reg.faultMeta;
		state_next.supplyMeta = supplyGood;
		state_next.supplySync = state_reg.supplyMeta;
		state_next.conversionStart = 1'b0;
		clearStatus  = 1'b0;
		releaseAlert = 1'b0;

		sclRise   = state_reg.sclSync & ~state_reg.sclPrev;
		sclFall   = ~state_reg.sclSync & state_reg.sclPrev;
		startCond = state_reg.sclSync & state_reg.sclPrev & state_reg.sdaPrev
			& ~state_reg.sdaSync;
		stopCond  = state_reg.sclSync & state_reg.sclPrev & ~state_reg.sdaPrev
			& state_reg.sdaSync;
		addrMatch = state_reg.shiftByte[7:1] == fan_thermal_pkg::DEVICE_ADDR;
		araMatch  = state_reg.shiftByte[7:1] == fan_thermal_pkg::ALERT_RESPONSE_ADDR
			&& state_reg.shiftByte[0] && state_reg.alertLatch;
		txByte = state_reg.alertResponse ? {fan_thermal_pkg::DEVICE_ADDR, 1'b1}
			: readMux(state_reg.pointer,
				statusByte(state_reg.faultFlags, state_reg.faultSync.converterBusy),
				state_reg.controlSettings);

		////////////////////////////////////////////////////////////////////
		// Bus engine

		case (state_reg.busState)
			fan_thermal_pkg::BUS_IDLE: begin
				state_next.sdaDrive = 1'b0;
			end
			fan_thermal_pkg::BUS_ADDR: begin
				if (sclRise) begin
					state_next.shiftByte = {state_reg.shiftByte[6:0], state_reg.sdaSync};
					state_next.bitCount  = state_reg.bitCount + 4'h1;
				end else if (sclFall && state_reg.bitCount == 4'h8) begin
					if (addrMatch || araMatch) begin
						state_next.alertResponse = araMatch;
						state_next.readNotWrite  = state_reg.shiftByte[0];
						state_next.sdaDrive      = 1'b1;
						state_next.busState      = fan_thermal_pkg::BUS_ACK;
					end else begin
						state_next.busState = fan_thermal_pkg::BUS_IDLE;
					end
				end
			end
			fan_thermal_pkg::BUS_ACK: begin
				if (sclFall) begin
					state_next.bitCount = 4'h0;
					if (state_reg.readNotWrite) begin
						state_next.shiftByte = txByte;
						state_next.sdaDrive  = ~txByte[7];
						state_next.busState  = fan_thermal_pkg::BUS_SEND;
					end else begin
						state_next.sdaDrive = 1'b0;
						state_next.busState = fan_thermal_pkg::BUS_RECV;
					end
				end
			end
			fan_thermal_pkg::BUS_RECV: begin
				if (sclRise) begin
					state_next.shiftByte = {state_reg.shiftByte[6:0], state_reg.sdaSync};
					state_next.bitCount  = state_reg.bitCount + 4'h1;
				end else if (sclFall && state_reg.bitCount == 4'h8) begin
					if (!state_reg.gotCommand) begin
						state_next.pointer    = state_reg.shiftByte;
						state_next.gotCommand = 1'b1;
						state_next.conversionStart =
							state_reg.shiftByte == fan_thermal_pkg::CMD_ONE_SHOT;
					end else if (state_reg.pointer == fan_thermal_pkg::CMD_WRITE_CONFIG) begin
						state_next.controlSettings = state_reg.shiftByte
							& fan_thermal_pkg::CONFIG_WRITABLE;
					end
					state_next.sdaDrive = 1'b1;
					state_next.busState = fan_thermal_pkg::BUS_ACK;
				end
			end
			fan_thermal_pkg::BUS_SEND: begin
				if (sclRise) begin
					state_next.bitCount = state_reg.bitCount + 4'h1;
				end else if (sclFall) begin
					if (state_reg.bitCount == 4'h8) begin
						state_next.sdaDrive = 1'b0;
						state_next.busState = fan_thermal_pkg::BUS_MACK;
					end else begin
						state_next.shiftByte = {state_reg.shiftByte[6:0], 1'b0};
						state_next.sdaDrive  = ~state_reg.shiftByte[6];
					end
				end
			end
			fan_thermal_pkg::BUS_MACK: begin
				if (sclRise) begin
					releaseAlert = state_reg.alertResponse;
					clearStatus  = ~state_reg.alertResponse
						&& state_reg.pointer == fan_thermal_pkg::CMD_READ_STATUS;
					state_next.busState = fan_thermal_pkg::BUS_IDLE;
				end
			end
			default: begin
				state_next.busState = fan_thermal_pkg::BUS_IDLE;
			end
		endcase

		if (startCond) begin
			state_next.busState   = fan_thermal_pkg::BUS_ADDR;
			state_next.bitCount   = 4'h0;
			state_next.gotCommand = 1'b0;
			state_next.sdaDrive   = 1'b0;
		end else if (stopCond) begin
			state_next.busState = fan_thermal_pkg::BUS_IDLE;
			state_next.sdaDrive = 1'b0;
		end

		// Clock-low watchdog
		if (state_reg.busState != fan_thermal_pkg::BUS_IDLE && !state_reg.sclSync) begin
			state_next.timeoutCount = state_reg.timeoutCount + 32'h1;
			if (state_reg.timeoutCount >= TIMEOUT_CYCLES) begin
				state_next.busState     = fan_thermal_pkg::BUS_IDLE;
				state_next.sdaDrive     = 1'b0;
				state_next.timeoutCount = 32'h0;
			end
		end else begin
			state_next.timeoutCount = 32'h0;
		end

		////////////////////////////////////////////////////////////////////
		// Fault flags and alert

		setFlags = 8'h00;
		setFlags[fan_thermal_pkg::ST_FAIL_BIT] = state_reg.faultSync.fanFailure
			& state_reg.controlSettings[fan_thermal_pkg::CFG_FAIL_DETECT_BIT];
		setFlags[fan_thermal_pkg::ST_CONTROL_BIT] = state_reg.faultSync.fanOutOfControl
			& state_reg.controlSettings[fan_thermal_pkg::CFG_CONTROL_LOSS_BIT];
		setFlags[fan_thermal_pkg::ST_DIODE3_BIT] = state_reg.faultSync.diodeThreeOpen;
		setFlags[fan_thermal_pkg::ST_DIODE2_BIT] = state_reg.faultSync.diodeTwoOpen;
		setFlags[fan_thermal_pkg::ST_DIODE1_BIT] = state_reg.faultSync.diodeOneOpen;
		state_next.faultFlags = (clearStatus ? 8'h00 : state_reg.faultFlags)
			| setFlags;

		state_next.alertLatch = (state_reg.alertLatch & ~releaseAlert)
			| ((|state_reg.faultFlags)
			& ~state_reg.controlSettings[fan_thermal_pkg::CFG_MASK_BIT]);
		state_next.alertDrive = state_next.alertLatch
			& ~state_reg.controlSettings[fan_thermal_pkg::CFG_MASK_BIT];

		////////////////////////////////////////////////////////////////////
		// Supply reset delay

		if (!state_reg.supplySync) begin
			state_next.resetCount   = 32'h0;
			state_next.resetRelease = 1'b0;
		end else if (state_reg.resetCount >= RESET_DELAY_CYCLES) begin
			state_next.resetRelease = 1'b1;
		end else begin
			state_next.resetCount = state_reg.resetCount + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= fan_thermal_pkg::REGS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sdaOut          = 1'b0;
	assign sdaOe_n         = ~state_reg.sdaDrive;
	assign alertOut        = 1'b0;
	assign alertOe_n       = ~state_reg.alertDrive;
	assign resetOut_n      = state_reg.resetRelease;
	assign conversionStart = state_reg.conversionStart;
	assign fanLoopSelect   = state_reg.controlSettings[fan_thermal_pkg::CFG_LOOP_BIT];

endmodule

// file: test/fan_thermal_checker.sv
/* Port checker of the fan monitor register block.
 Bound from tb; sees top ports only. */
`timescale 1ns/1ps
module fan_thermal_checker #(
	parameter int unsigned TIMEOUT_CYCLES     = 200,
	parameter int unsigned RESET_DELAY_CYCLES = 50
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOe_n,
	input wire logic alertOut,
	input wire logic alertOe_n,
	input wire logic supplyGood,
	input wire logic resetOut_n,
	input wire logic conversionStart
);
	int unsigned supCnt;
	int unsigned lowCnt;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			supCnt <= 0;
			lowCnt <= 0;
		end else begin
			supCnt <= supplyGood ? supCnt + 1 : 0;
			lowCnt <= (!sclIn && !sdaOe_n) ? lowCnt + 1 : 0;
		end
	end
	////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_reset_hold: assert property (!supplyGood [*6] |-> !resetOut_n)
		else $error("reset out high without supply");
	a_reset_early: assert property (
		$rose(resetOut_n) |-> supCnt >= RESET_DELAY_CYCLES)
		else $error("reset out released early");
	a_reset_late: assert property (
		supCnt == RESET_DELAY_CYCLES + 8 |-> resetOut_n)
		else $error("reset out released late");
	a_conv_pulse: assert property (conversionStart |=> !conversionStart)
		else $error("conversion start too long");
	a_sda_steady: assert property (
		sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe_n))
		else $error("data moved while clock high");
	a_sda_launch: assert property ($changed(sdaOe_n) |-> !$past(sclIn, 2))
		else $error("data launched off clock low");
	a_bus_timeout: assert property (lowCnt <= TIMEOUT_CYCLES + 8)
		else $error("bus not released on timeout");
	a_drive_zero: assert property (!sdaOut && !alertOut)
		else $error("open drain value not low");
	c_conv: cover property (conversionStart);
	c_rst: cover property ($rose(resetOut_n));
	c_alert: cover property ($fell(alertOe_n));
endmodule

// file: test/smbus_host.sv
/* SMBus host model: drives SCL, pulls SDA low.
 Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module smbus_host (
	input  wire logic sysClk,
	input  wire logic sdaLine,
	output logic      sclOut,
	output logic      sdaPull
);
	initial begin
		sclOut = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask
	task automatic start();
		sdaPull = 1'b0;
		tick(2);
		sclOut = 1'b1;
		tick(4);
		sdaPull = 1'b1;
		tick(4);
		sclOut = 1'b0;
	endtask
	task automatic stop();
		sdaPull = 1'b1;
		tick(2);
		sclOut = 1'b1;
		tick(4);
		sdaPull = 1'b0;
		tick(4);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [8:0] r);
		logic [8:0] v;
		v = {d, a};
		for (int i = 8; i >= 0; i--) begin
			sdaPull = !v[i];
			tick(2);
			sclOut = 1'b1;
			tick(2);
			r[i] = sdaLine;
			tick(2);
			sclOut = 1'b0;
			tick(2);
		end
	endtask
	////////////////////////////////
	// Kind 0 write, 1 send, 2 read, 3 receive
	task automatic access(input logic [6:0] a, input logic [7:0] c, input logic [7:0] w,
		input int k, output logic [7:0] rd);
		logic [8:0] r;
		if (k != 3) begin
			start();
			xbyte({a, 1'b0}, 1'b1, r);
			xbyte(c, 1'b1, r);
			if (k == 0)
				xbyte(w & fan_thermal_pkg::CONFIG_WRITABLE, 1'b1, r);
		end
		if (k >= 2) begin
			start();
			xbyte({a, 1'b1}, 1'b1, r);
			xbyte(8'hFF, 1'b1, r);
		end
		stop();
		rd = r[8:1];
	endtask
endmodule

// file: test/tb.sv
/* Self-checking bench of the fan monitor register block.
 SMBus traffic comes from the host model, 80 ns bits. */
`timescale 1ns/1ps
module tb;
	localparam logic [6:0] DEV = fan_thermal_pkg::DEVICE_ADDR;
	logic                       sys_clk, reset_n, supplyGood, hostScl, hostPull;
	logic                       sdaOut, sdaOe_n, alertOut, alertOe_n;
	logic                       resetOut_n, conversionStart, fanLoopSelect;
	wire logic                  sdaLine;
	fan_thermal_pkg::fault_in_t faults;
	logic [7:0]                 d;
	logic [8:0]                 r;
	int                         miscompares, total_checks, cycles, pulses;
	assign sdaLine = !hostPull && (sdaOe_n || sdaOut);
	fan_thermal_status_config_regs #(.TIMEOUT_CYCLES(200), .RESET_DELAY_CYCLES(50)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .sclIn(hostScl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .alertOut(alertOut), .alertOe_n(alertOe_n),
		.faultIn(faults), .supplyGood(supplyGood), .resetOut_n(resetOut_n),
		.conversionStart(conversionStart), .fanLoopSelect(fanLoopSelect));
	smbus_host host (.sysClk(sys_clk), .sdaLine(sdaLine), .sclOut(hostScl), .sdaPull(hostPull));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (conversionStart)
			pulses++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	////////////////////////////////
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic op(input logic [7:0] c, input logic [7:0] w, input int k);
		host.access(DEV, c, w, k, d);
	endtask
	task automatic pulse(input logic [5:0] f);
		faults = fan_thermal_pkg::fault_in_t'(f);
		host.tick(5);
		faults = '0;
		host.tick(5);
	endtask
	initial begin
		reset_n = 1'b0;
		faults = '0;
		supplyGood = 1'b0;
		host.tick(6);
		reset_n = 1'b1;
		host.tick(4);
		op(8'h03, 8'h00, 2);
		check("config", d, 8'h02);
		check("loop", 8'(fanLoopSelect), 8'h01);
		check("rstout", 8'(resetOut_n), 8'h00);
		pulse(6'h38);
		op(8'h02, 8'h00, 2);
		check("nodetect", d, 8'h00);
		check("alertidle", 8'(alertOe_n), 8'h01);
		op(8'h09, 8'h30, 0);
		op(8'h03, 8'h00, 2);
		check("cfgwr", d, 8'h30);
		check("loop0", 8'(fanLoopSelect), 8'h00);
		op(8'h00, 8'h00, 3);
		check("recv", d, 8'h30);
		$display("test config done");
		pulse(6'h1F);
		faults.converterBusy = 1'b1;
		host.tick(4);
		check("alert", 8'(alertOe_n), 8'h00);
		op(8'h02, 8'h00, 2);
		check("status", d, 8'hEE);
		faults = '0;
		host.tick(4);
		op(8'h02, 8'h00, 2);
		check("cleared", d, 8'h00);
		check("latched", 8'(alertOe_n), 8'h00);
		host.access(fan_thermal_pkg::ALERT_RESPONSE_ADDR, 8'h00, 8'h00, 3, d);
		check("ara", d, 8'h7B);
		host.tick(4);
		check("released", 8'(alertOe_n), 8'h01);
		faults = 6'h01;
		host.tick(4);
		op(8'h02, 8'h00, 2);
		check("live", d, 8'h02);
		faults = '0;
		op(8'h02, 8'h00, 2);
		check("kept", d, 8'h02);
		op(8'h02, 8'h00, 2);
		check("gone", d, 8'h00);
		$display("test status done");
		op(8'h09, 8'hB0, 0);
		host.tick(4);
		check("masked", 8'(alertOe_n), 8'h01);
		pulse(6'h02);
		check("stillmasked", 8'(alertOe_n), 8'h01);
		op(8'h02, 8'h00, 2);
		check("diode2", d, 8'h04);
		op(8'h0F, 8'h00, 1);
		check("conv", 8'(pulses), 8'h01);
		host.start();
		host.tick(300);
		host.xbyte({DEV, 1'b0}, 1'b1, r);
		host.stop();
		check("noack", 8'(r[0]), 8'h01);
		op(8'h03, 8'h00, 2);
		check("after", d, 8'hB0);
		$display("test bus done");
		supplyGood = 1'b1;
		host.tick(45);
		check("rsthold", 8'(resetOut_n), 8'h00);
		host.tick(20);
		check("rsthigh", 8'(resetOut_n), 8'h01);
		supplyGood = 1'b0;
		host.tick(6);
		check("rstdrop", 8'(resetOut_n), 8'h00);
		$display("test supply done");
		reset_n = 1'b0;
		host.tick(2);
		check("rstloop", 8'(fanLoopSelect), 8'h01);
		reset_n = 1'b1;
		host.tick(4);
		op(8'h03, 8'h00, 2);
		check("rstcfg", d, 8'h02);
		check("rstalert", 8'(alertOe_n), 8'h01);
		$display("test reset done");
		final_report();
	end
endmodule
bind fan_thermal_status_config_regs fan_thermal_checker #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .sclIn(sclIn), .sdaOut(sdaOut),
	.sdaOe_n(sdaOe_n), .alertOut(alertOut), .alertOe_n(alertOe_n),
	.supplyGood(supplyGood), .resetOut_n(resetOut_n), .conversionStart(conversionStart));
